// File: inc/disk_glue_pkg.sv
// Constants shared by the disk host interface glue block
package disk_glue_pkg;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] CONTROL_OFFSET    = 8'h00;
   localparam logic [7:0] COMMAND_OFFSET    = 8'h04;
   localparam logic [7:0] STATUS_OFFSET     = 8'h08;
   localparam logic [7:0] COUNTERS_OFFSET   = 8'h0c;
   localparam int         ADDR_WIDTH        = 8;
   localparam int         DATA_WIDTH        = 32;

   // ==========================================================
   // Control register fields
   localparam int         CTRL_HOLD_ENABLE  = 0;
   localparam int         CTRL_SQ_ENABLE    = 1;
   localparam logic [1:0] CONTROL_RESET     = 2'h0;

   // ==========================================================
   // Command register fields (write one for a pulse)
   localparam int         CMD_HOLD_CLEAR_A  = 0;
   localparam int         CMD_HOLD_CLEAR_B  = 1;
   localparam int         CMD_INDEX_CLEAR   = 2;

   // ==========================================================
   // Status register fields
   localparam int         ST_HOLD_ACTIVE    = 0;
   localparam int         ST_QUAL_SELECT    = 1;
   localparam int         ST_LATCHED_INDEX  = 2;
   localparam int         ST_MARK_DELAYED   = 3;
   localparam int         ST_BYTE_STROBE    = 4;
   localparam int         ST_TIMING_CLOCK   = 5;
   localparam int         ST_MARK_IN        = 6;
   localparam int         ST_CARD_SELECT    = 7;

   // ==========================================================
   // Bus responses
   localparam logic [1:0] RESP_OKAY         = 2'h0;
   localparam logic [1:0] RESP_DECERR       = 2'h3;

   // ==========================================================
   // Timing counts
   localparam int         TIMING_DIVIDE     = 16;
   localparam int         TIMING_HALF       = TIMING_DIVIDE / 2;
   localparam int         BITS_PER_BYTE     = 8;
   localparam int         MARK_DELAY        = 2;
   localparam int         COUNT_WIDTH       = 16;

endpackage

// File: logic/pin_sync_edge.sv
// Two-flop synchroniser with edge detection for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync_edge #(
   parameter int          WIDTH = 1
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [WIDTH-1:0]  pin,
   output logic      [WIDTH-1:0]  level,
   output logic      [WIDTH-1:0]  rise,
   output logic      [WIDTH-1:0]  fall
);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] prev;

   // ==========================================================
   // Synchroniser, first stage read only by second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta  <= '0;
         level <= '0;
         prev  <= '0;
      end else begin
         meta  <= pin;
         level <= meta;
         prev  <= level;
      end
   end

   // ==========================================================
   // Edge detection on synchronised level
   assign rise = level & ~prev;
   assign fall = ~level & prev;

endmodule
`default_nettype wire

// File: logic/event_divider.sv
// Event counter that flags every DIVIDE-th step
`timescale 1ns/1ps
`default_nettype none
module event_divider #(
   parameter int DIVIDE = 8,
   parameter int WIDTH  = $clog2(DIVIDE)
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              restart,
   input  wire logic              step,
   output logic                   terminal
);

   localparam logic [WIDTH-1:0] LAST = WIDTH'(DIVIDE - 1);

   logic [WIDTH-1:0] count;

   // ==========================================================
   // Step counter, wraps after the last step
   always_ff @(posedge aclk) begin
      if (!aresetn || restart) begin
         count <= '0;
      end else if (step) begin
         if (count == LAST) begin
            count <= '0;
         end else begin
            count <= count + WIDTH'(1);
         end
      end
   end

   assign terminal = step && !restart && (count == LAST);

endmodule
`default_nettype wire

// File: logic/disk_host_interface_glue.sv
// Host and drive glue logic for a hard disk controller, AXI4-Lite controlled
`timescale 1ns/1ps
`default_nettype none

module disk_host_interface_glue
   import disk_glue_pkg::*;
(
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // AXI4-Lite write address
   input  wire logic [ADDR_WIDTH-1:0]  s_axi_awaddr,
   input  wire logic [2:0]             s_axi_awprot,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [DATA_WIDTH-1:0]  s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   // AXI4-Lite write response
   output logic      [1:0]             s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [ADDR_WIDTH-1:0]  s_axi_araddr,
   input  wire logic [2:0]             s_axi_arprot,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   // AXI4-Lite read data
   output logic      [DATA_WIDTH-1:0]  s_axi_rdata,
   output logic      [1:0]             s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // Host side pins
   input  wire logic                   card_select_n,
   output logic                        hold_n,
   output logic                        qualified_card_select,
   // Drive side pins
   input  wire logic                   write_clock,
   input  wire logic                   read_clock,
   input  wire logic                   index_n,
   input  wire logic                   mark_detect_in,
   output logic                        drive_timing_clock_out,
   output logic                        latched_index,
   output logic                        mark_detect_delayed,
   output logic                        read_byte_strobe,
   output logic                        read_clock_echo
);

   // ==========================================================
   // Declarations
   logic [4:0]             pin_level, pin_rise, pin_fall;
   logic                   cs_active, cs_fall, write_rise, read_fall, index_fall;
   logic                   mark_level, mark_rise, timing_toggle, byte_terminal;
   logic                   aw_full, w_full, ar_full, write_fire, write_hit, read_hit;
   logic [ADDR_WIDTH-1:0]  aw_addr, ar_addr;
   logic [DATA_WIDTH-1:0]  w_data, next_rdata;
   logic [3:0]             w_strb;
   logic [1:0]             control;
   logic                   hold_enable, select_qualify_enable, hold_clear_any;
   logic                   hold_clear_a, hold_clear_b, index_latch_clear;
   logic [MARK_DELAY-1:0]  mark_pipe;
   logic [COUNT_WIDTH-1:0] byte_count, index_count;
   logic [7:0]             status;

   // ==========================================================
   // Pin synchronisers
   pin_sync_edge #(
      .WIDTH   (5)
   ) pins (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     ({mark_detect_in, ~index_n, read_clock, write_clock, ~card_select_n}),
      .level   (pin_level),
      .rise    (pin_rise),
      .fall    (pin_fall)
   );

   assign cs_active  = pin_level[0];
   assign cs_fall    = pin_rise[0];
   assign write_rise = pin_rise[1];
   assign read_fall  = pin_fall[2];
   assign index_fall = pin_rise[3];
   assign mark_level = pin_level[4];
   assign mark_rise  = pin_rise[4];

   // ==========================================================
   // Write address and data channels
   assign write_fire = aw_full && w_full && !s_axi_bvalid;
   assign write_hit  = (aw_addr == CONTROL_OFFSET) || (aw_addr == COMMAND_OFFSET)
                       || (aw_addr == STATUS_OFFSET) || (aw_addr == COUNTERS_OFFSET);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         aw_full       <= 1'b0;
         aw_addr       <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_full       <= 1'b1;
         aw_addr       <= s_axi_awaddr;
      end else if (write_fire) begin
         aw_full       <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b1;
         w_full       <= 1'b0;
         w_data       <= '0;
         w_strb       <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_full       <= 1'b1;
         w_data       <= s_axi_wdata;
         w_strb       <= s_axi_wstrb;
      end else if (write_fire) begin
         w_full       <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   // ==========================================================
   // Write response channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (write_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= write_hit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control <= CONTROL_RESET;
      end else if (write_fire && aw_addr == CONTROL_OFFSET && w_strb[0]) begin
         control <= w_data[1:0];
      end
   end

   assign hold_enable           = control[CTRL_HOLD_ENABLE];
   assign select_qualify_enable = control[CTRL_SQ_ENABLE];

   // ==========================================================
   // Command pulses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_clear_a      <= 1'b0;
         hold_clear_b      <= 1'b0;
         index_latch_clear <= 1'b0;
      end else begin
         hold_clear_a      <= 1'b0;
         hold_clear_b      <= 1'b0;
         index_latch_clear <= 1'b0;
         if (write_fire && aw_addr == COMMAND_OFFSET && w_strb[0]) begin
            hold_clear_a      <= w_data[CMD_HOLD_CLEAR_A];
            hold_clear_b      <= w_data[CMD_HOLD_CLEAR_B];
            index_latch_clear <= w_data[CMD_INDEX_CLEAR];
         end
      end
   end

   assign hold_clear_any = hold_clear_a || hold_clear_b;

   // ==========================================================
   // Hold latch
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_n <= 1'b1;
      end else if (hold_enable && cs_fall) begin
         hold_n <= 1'b0;
      end else if (hold_clear_any) begin
         hold_n <= 1'b1;
      end
   end

   // ==========================================================
   // Qualified card select
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         qualified_card_select <= 1'b0;
      end else if (hold_clear_any) begin
         qualified_card_select <= 1'b0;
      end else begin
         qualified_card_select <= cs_active && select_qualify_enable;
      end
   end

   // ==========================================================
   // Drive timing clock
   event_divider #(
      .DIVIDE   (TIMING_HALF)
   ) timing_div (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .restart  (1'b0),
      .step     (write_rise),
      .terminal (timing_toggle)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drive_timing_clock_out <= 1'b1;
      end else if (timing_toggle) begin
         drive_timing_clock_out <= ~drive_timing_clock_out;
      end
   end

   // ==========================================================
   // Latched index
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latched_index <= 1'b0;
      end else if (index_fall) begin
         latched_index <= 1'b1;
      end else if (index_latch_clear) begin
         latched_index <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         index_count <= '0;
      end else if (index_fall) begin
         index_count <= index_count + COUNT_WIDTH'(1);
      end
   end

   // ==========================================================
   // Delayed mark
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mark_pipe           <= '0;
         mark_detect_delayed <= 1'b0;
      end else if (read_fall) begin
         mark_pipe           <= {mark_pipe[MARK_DELAY-2:0], mark_level};
         mark_detect_delayed <= mark_pipe[MARK_DELAY-1];
      end
   end

   // ==========================================================
   // Read byte strobe
   event_divider #(
      .DIVIDE   (BITS_PER_BYTE)
   ) byte_div (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .restart  (mark_rise),
      .step     (read_fall),
      .terminal (byte_terminal)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         read_byte_strobe <= 1'b0;
      end else if (mark_rise) begin
         read_byte_strobe <= 1'b0;
      end else if (read_fall) begin
         read_byte_strobe <= byte_terminal;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         byte_count <= '0;
      end else if (mark_rise) begin
         byte_count <= '0;
      end else if (byte_terminal) begin
         byte_count <= byte_count + COUNT_WIDTH'(1);
      end
   end

   // ==========================================================
   // Read clock echo
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         read_clock_echo <= 1'b0;
      end else begin
         read_clock_echo <= pin_level[2];
      end
   end

   // ==========================================================
   // Read address channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         ar_full       <= 1'b0;
         ar_addr       <= '0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         ar_full       <= 1'b1;
         ar_addr       <= s_axi_araddr;
      end else if (ar_full && !s_axi_rvalid) begin
         ar_full       <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
      end
   end

   // ==========================================================
   // Read data mux
   assign status = {cs_active, mark_level, drive_timing_clock_out, read_byte_strobe,
                    mark_detect_delayed, latched_index, qualified_card_select, ~hold_n};

   always_comb begin
      next_rdata = '0;
      read_hit   = 1'b1;
      case (ar_addr)
         CONTROL_OFFSET:  next_rdata = {30'h0, control};
         COMMAND_OFFSET:  next_rdata = '0;
         STATUS_OFFSET:   next_rdata = {24'h0, status};
         COUNTERS_OFFSET: next_rdata = {index_count, byte_count};
         default:         read_hit   = 1'b0;
      endcase
   end

   // ==========================================================
   // Read data channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (ar_full && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= read_hit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// File: tb/glue_props.sv
// Checker for the host and drive pin timing of the glue block
`timescale 1ns/1ps
`default_nettype none
module glue_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_bvalid,
   input wire logic card_select_n,
   input wire logic hold_n,
   input wire logic qualified_card_select,
   input wire logic read_clock,
   input wire logic index_n,
   input wire logic mark_detect_in,
   input wire logic drive_timing_clock_out,
   input wire logic latched_index,
   input wire logic mark_detect_delayed,
   input wire logic read_byte_strobe,
   input wire logic read_clock_echo
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // =====
   // Gap between timing clock changes
   logic       prev_tc;
   logic       armed;
   logic [7:0] gap;
   always_ff @(posedge aclk) begin
      prev_tc <= drive_timing_clock_out;
      if (!aresetn || prev_tc != drive_timing_clock_out) gap <= 8'h00;
      else gap <= gap + 8'h01;
      if (!aresetn) armed <= 1'b0;
      else if (prev_tc != drive_timing_clock_out) armed <= 1'b1;
   end
   // =====
   // Properties
   sequence strobe_pulse;
      read_byte_strobe [*8] ##1 !read_byte_strobe;
   endsequence
   chk_reset_state: assert property ($rose(aresetn) |-> hold_n && drive_timing_clock_out
      && !qualified_card_select && !read_byte_strobe && !mark_detect_delayed)
      else $error("reset state wrong");
   chk_timing_divide: assert property (armed && $changed(drive_timing_clock_out)
      |-> gap == 8'h4f) else $error("timing clock period wrong");
   chk_echo_delay: assert property ($past(aresetn, 3)
      |-> read_clock_echo == $past(read_clock, 3)) else $error("echo delay wrong");
   chk_hold_set: assert property ($fell(hold_n) |-> !$past(card_select_n, 2)
      && ($past(card_select_n, 4) || $past(card_select_n, 5) || $past(card_select_n, 6)))
      else $error("hold set without select edge");
   chk_hold_release: assert property ($rose(hold_n)
      |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("hold released alone");
   chk_index_set: assert property ($rose(latched_index) |-> !$past(index_n, 2)
      && ($past(index_n, 4) || $past(index_n, 5) || $past(index_n, 6)))
      else $error("index latched without pulse");
   chk_index_clear: assert property ($fell(latched_index)
      |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("index cleared alone");
   chk_qual_select: assert property ($rose(qualified_card_select)
      |-> !$past(card_select_n, 2)) else $error("qualified select without select");
   chk_mark_delay: assert property ($rose(mark_detect_delayed)
      |-> $past(mark_detect_in, 19) && !$past(mark_detect_in, 28)) else $error("mark delay wrong");
   chk_strobe_width: assert property ($rose(read_byte_strobe) && !mark_detect_in
      |-> strobe_pulse or ##[1:7] $rose(mark_detect_in)) else $error("strobe width wrong");
endmodule
`default_nettype wire

// File: tb/drive_model.sv
// Drive side model: bit clocks, index pulse and mark detector
`timescale 1ns/1ps
`default_nettype none
module drive_model (
   input  wire logic aclk,
   input  wire logic mark_go,
   output logic      write_clock,
   output logic      read_clock,
   output logic      index_n,
   output logic      mark_detect_in
);
   logic [9:0] turn      = 10'h200;
   logic [3:0] wphase    = 4'h0;
   logic [5:0] mark_left = 6'h00;
   initial begin
      write_clock = 1'b0;
      read_clock = 1'b0;
      index_n = 1'b1;
      mark_detect_in = 1'b0;
   end
   // =====
   // Bit clocks and one index per turn
   always @(posedge aclk) begin
      turn <= turn + 10'h001;
      wphase <= (wphase == 4'h9) ? 4'h0 : wphase + 4'h1;
      write_clock <= (wphase < 4'h5);
      read_clock <= turn[2];
      index_n <= (turn > 10'h007);
   end
   // =====
   // Mark found at a read clock rise
   always @(posedge aclk) begin
      if (mark_go && turn[2:0] == 3'h4) begin
         mark_left <= 6'h30;
         mark_detect_in <= 1'b1;
      end else if (mark_left != 6'h00) mark_left <= mark_left - 6'h01;
      else mark_detect_in <= 1'b0;
   end
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking testbench for the disk host interface glue
`timescale 1ns/1ps
`default_nettype none
module testbench
   import disk_glue_pkg::*;
;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        card_select_n = 1'b1;
   logic        mark_go = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        hold_n, qualified_card_select, write_clock, read_clock, index_n;
   logic        mark_detect_in, drive_timing_clock_out, latched_index, mark_detect_delayed;
   logic        read_byte_strobe, read_clock_echo;
   logic [1:0]  bnotes[$];
   logic [65:0] rnotes[$];
   logic [65:0] note;
   int          checked = 0;
   int          n_fail = 0;
   always #10 aclk = ~aclk;
   disk_host_interface_glue dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr,
      .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready(1'b1), .card_select_n, .hold_n, .qualified_card_select,
      .write_clock, .read_clock, .index_n, .mark_detect_in, .drive_timing_clock_out,
      .latched_index, .mark_detect_delayed, .read_byte_strobe, .read_clock_echo);
   drive_model drive (.aclk, .mark_go, .write_clock, .read_clock, .index_n, .mark_detect_in);
   // =====
   // Checking and closing
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wait_for(input string what, ref logic sig, input logic val, input int lim);
      int n;
      n = 0;
      while (sig !== val && n < lim) begin
         @(posedge aclk);
         n++;
      end
      check(what, 32'(sig), 32'(val));
      if (n >= lim) end_sim();
   endtask
   always @(posedge aclk) begin
      if (s_axi_bvalid) check("bresp", 32'(s_axi_bresp), 32'(bnotes.pop_front()));
      if (s_axi_rvalid) begin
         note = rnotes.pop_front();
         check("rresp", 32'(s_axi_rresp), 32'(note[65:64]));
         check("rdata", s_axi_rdata & note[63:32], note[31:0]);
      end
   end
   // =====
   // Register bus master
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      n = 0;
      bnotes.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      if (s_axi_bvalid !== 1'b1) begin
         n_fail++;
         end_sim();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] m,
                     input logic [31:0] d);
      int n;
      n = 0;
      rnotes.push_back({r, m, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      if (s_axi_rvalid !== 1'b1) begin
         n_fail++;
         end_sim();
      end
   endtask
   // =====
   // Main sequence
   initial begin
      int          i;
      int          k;
      int          nb;
      logic        p;
      logic [31:0] v;
      void'($urandom(32'h9bff2262));
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check("reset pins", 32'({hold_n, qualified_card_select, drive_timing_clock_out,
         latched_index, mark_detect_delayed, read_byte_strobe}), 32'h28);
      rd(CONTROL_OFFSET, RESP_OKAY, 32'hffffffff, 32'h0);
      rd(COMMAND_OFFSET, RESP_OKAY, 32'hffffffff, 32'h0);
      wr(STATUS_OFFSET, 32'h0, RESP_OKAY);
      wr(8'h10, 32'h3, RESP_DECERR);
      rd(8'h10, RESP_DECERR, 32'hffffffff, 32'h0);
      $display("test reset done");
      for (i = 0; i < 4; i++) begin
         v = $urandom;
         wr(CONTROL_OFFSET, v, RESP_OKAY);
         rd(CONTROL_OFFSET, RESP_OKAY, 32'hffffffff, v & 32'h3);
      end
      $display("test control done");
      wr(CONTROL_OFFSET, 32'h3, RESP_OKAY);
      for (i = 0; i < 2; i++) begin
         card_select_n <= 1'b0;
         wait_for("hold set", hold_n, 1'b0, 8);
         wait_for("qualified", qualified_card_select, 1'b1, 8);
         rd(STATUS_OFFSET, RESP_OKAY, 32'h3, 32'h3);
         wr(COMMAND_OFFSET, 32'(1 << i), RESP_OKAY);
         wait_for("hold released", hold_n, 1'b1, 4);
         card_select_n <= 1'b1;
         repeat (8) @(posedge aclk);
      end
      $display("test hold done");
      wr(CONTROL_OFFSET, 32'h0, RESP_OKAY);
      card_select_n <= 1'b0;
      repeat (10) @(posedge aclk);
      check("hold disabled", 32'({hold_n, qualified_card_select}), 32'h2);
      card_select_n <= 1'b1;
      $display("test hold_off done");
      wait_for("index pulse", index_n, 1'b0, 1100);
      wait_for("index latched", latched_index, 1'b1, 8);
      wr(COMMAND_OFFSET, 32'h4, RESP_OKAY);
      wait_for("index cleared", latched_index, 1'b0, 4);
      $display("test index done");
      mark_go <= 1'b1;
      wait_for("mark raised", mark_detect_in, 1'b1, 20);
      mark_go <= 1'b0;
      p = read_clock;
      k = 0;
      nb = 0;
      while (read_byte_strobe !== 1'b1 && nb < 200) begin
         @(posedge aclk);
         nb++;
         if (p && !read_clock) k++;
         p = read_clock;
      end
      check("falls to strobe", 32'(k), 32'h8);
      nb = 1 + $urandom % 4;
      repeat (nb - 1) begin
         wait_for("strobe low", read_byte_strobe, 1'b0, 20);
         wait_for("strobe high", read_byte_strobe, 1'b1, 80);
      end
      rd(COUNTERS_OFFSET, RESP_OKAY, 32'hffffffff, {16'h0001, 16'(nb)});
      $display("test mark done");
      end_sim();
   end
endmodule
bind disk_host_interface_glue glue_props chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_bvalid(s_axi_bvalid), .card_select_n(card_select_n), .hold_n(hold_n),
   .qualified_card_select(qualified_card_select), .read_clock(read_clock),
   .index_n(index_n), .mark_detect_in(mark_detect_in),
   .drive_timing_clock_out(drive_timing_clock_out), .latched_index(latched_index),
   .mark_detect_delayed(mark_detect_delayed), .read_byte_strobe(read_byte_strobe),
   .read_clock_echo(read_clock_echo));
`default_nettype wire
